// [verilog/imt_pkg.sv]
// interrupt mitigation and general-purpose timer constants
// assumes a single 100 MHz core clock; nothing imported by users
package imt_pkg;

  // ----------------------------------------------------------------
  // clock and time units
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int UNIT_SHORT_100_NS  = 5120;    // 5.12 us
  localparam int UNIT_SHORT_10_NS   = 51200;   // 51.2 us
  localparam int UNIT_LONG_100_NS   = 81920;   // 81.92 us
  localparam int UNIT_LONG_10_NS    = 819200;  // 819.2 us
  localparam int UNIT_SHORT_100_CYC = UNIT_SHORT_100_NS / CLK_PERIOD_NS;
  localparam int UNIT_SHORT_10_CYC  = UNIT_SHORT_10_NS / CLK_PERIOD_NS;
  localparam int LONG_PER_SHORT     = UNIT_LONG_100_NS / UNIT_SHORT_100_NS;
  localparam logic [3:0] LONG_LAST  = 4'(LONG_PER_SHORT - 1);
  localparam int TX_TMR_UNITS       = 16;
  localparam logic [3:0] TX_SUB_LAST = 4'(TX_TMR_UNITS - 1);

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS  = 8'h00;
  localparam logic [7:0]  STAT_OFS  = 8'h04;
  localparam logic [7:0]  MASK_OFS  = 8'h08;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [2:0]  STAT_RST  = 3'h0;
  localparam logic [2:0]  MASK_RST  = 3'h0;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CS_POS  = 31;
  localparam int TT_LSB  = 27;
  localparam int NTP_LSB = 24;
  localparam int RT_LSB  = 20;
  localparam int NRP_LSB = 17;
  localparam int CON_POS = 16;
  localparam int TIM_LSB = 0;

  // ----------------------------------------------------------------
  // status and mask bits
  // ----------------------------------------------------------------
  localparam int ST_TX = 0;
  localparam int ST_RX = 1;
  localparam int ST_GP = 2;

endpackage

// [verilog/imt_tick_if.sv]
// time-unit ticks passed from the divider to the mitigation logic
// assumes both ends share core_clk
`timescale 1ns/100ps
`default_nettype none
interface imt_tick_if;
  logic speed_100;   // 1: 100 Mbps units, 0: 10 Mbps units
  logic cycle_size;  // 1: short unit, 0: long unit
  logic unit_tick;   // one-cycle pulse per mitigation unit
  logic long_tick;   // one-cycle pulse per timer iteration

  modport gen (input speed_100, input cycle_size,
               output unit_tick, output long_tick);
  modport use_t (output speed_100, output cycle_size,
                 input unit_tick, input long_tick);
endinterface
`default_nettype wire

// [verilog/imt_tick_gen.sv]
// divider making the short and long time-unit enable pulses
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module imt_tick_gen #(
  parameter int SHORT_100_CYC = imt_pkg::UNIT_SHORT_100_CYC,
  parameter int SHORT_10_CYC  = imt_pkg::UNIT_SHORT_10_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // ticks
  imt_tick_if.gen  tk
);
  localparam int PMAX = (SHORT_100_CYC > SHORT_10_CYC) ?
                        SHORT_100_CYC : SHORT_10_CYC;
  localparam int PW   = $clog2(PMAX + 1);

  logic [PW-1:0] pre_r;
  logic [3:0]    grp_r;
  logic          short_r;
  logic          long_r;
  wire  [PW-1:0] pre_lim;
  wire           pre_wrap;

  // prescale limit follows link speed; >= guards a speed change
  assign pre_lim  = tk.speed_100 ? PW'(SHORT_100_CYC - 1) :
                                   PW'(SHORT_10_CYC - 1);
  assign pre_wrap = (pre_r >= pre_lim);

  // short unit prescaler
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pre_r   <= '0;
      short_r <= 1'b0;
    end else begin
      pre_r   <= pre_wrap ? '0 : pre_r + PW'(1);
      short_r <= pre_wrap;
    end
  end

  // long unit is sixteen short units
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      grp_r  <= 4'h0;
      long_r <= 1'b0;
    end else begin
      grp_r  <= pre_wrap ? grp_r + 4'h1 : grp_r;
      long_r <= pre_wrap && (grp_r == imt_pkg::LONG_LAST);
    end
  end

  // unit chosen by cycle size
  assign tk.unit_tick = tk.cycle_size ? short_r : long_r;
  assign tk.long_tick = long_r;
endmodule
`default_nettype wire

// [verilog/imt_top.sv]
// interrupt mitigation counters/timers and general-purpose timer
// assumes one 100 MHz clock and frame-done pulses from the mac
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module imt_top #(
  parameter int SHORT_100_CYC = imt_pkg::UNIT_SHORT_100_CYC,
  parameter int SHORT_10_CYC  = imt_pkg::UNIT_SHORT_10_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // mac events
  input  wire logic        speed_100,
  input  wire logic        tx_frame_done,
  input  wire logic        rx_frame_done,
  // interrupt
  output logic             irq
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic        cs_r, con_r;
  logic [3:0]  tt_cfg_r, rt_cfg_r;
  logic [2:0]  ntp_cfg_r, nrp_cfg_r;
  logic [15:0] tim_cfg_r;
  logic [3:0]  tt_cnt_r, tt_sub_r, rt_cnt_r;
  logic [2:0]  ntp_cnt_r, nrp_cnt_r;
  logic [15:0] gp_cnt_r;
  logic [2:0]  st_r, mask_r;
  logic [31:0] rdata_r;
  logic        irq_r;

  imt_tick_if tk ();

  imt_tick_gen #(
    .SHORT_100_CYC (SHORT_100_CYC),
    .SHORT_10_CYC  (SHORT_10_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tk       (tk)
  );

  assign tk.speed_100  = speed_100;
  assign tk.cycle_size = cs_r;

  // true when a count sits on its last step
  function automatic logic at_one(input logic [3:0] c);
    return c == 4'h1;
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == imt_pkg::CTRL_OFS);
  wire wr_stat = reg_wr && (reg_addr == imt_pkg::STAT_OFS);
  wire wr_mask = reg_wr && (reg_addr == imt_pkg::MASK_OFS);

  wire [3:0]  w_tt  = reg_wdata[imt_pkg::TT_LSB +: 4];
  wire [2:0]  w_ntp = reg_wdata[imt_pkg::NTP_LSB +: 3];
  wire [3:0]  w_rt  = reg_wdata[imt_pkg::RT_LSB +: 4];
  wire [2:0]  w_nrp = reg_wdata[imt_pkg::NRP_LSB +: 3];
  wire [15:0] w_tim = reg_wdata[imt_pkg::TIM_LSB +: 16];

  // ----------------------------------------------------------------
  // transmit mitigation
  // ----------------------------------------------------------------
  wire tt_on   = (tt_cfg_r != 4'h0);
  wire ntp_on  = (ntp_cfg_r != 3'h0);
  wire tt_run  = (tt_cnt_r != 4'h0);
  // timer steps once per sixteen units
  wire tt_step = tt_run && tk.unit_tick &&
                 (tt_sub_r == imt_pkg::TX_SUB_LAST);
  wire tx_tmr_hit = tt_step && at_one(tt_cnt_r);
  wire tx_cnt_hit = tx_frame_done && ntp_on &&
                    at_one({1'b0, ntp_cnt_r});
  wire tx_nomit   = tx_frame_done && !ntp_on && !tt_on;
  wire tx_set     = tx_cnt_hit || tx_tmr_hit || tx_nomit;

  // tx counter: decrement per frame, reload on flag
  wire [2:0] ntp_nxt = wr_ctrl ? w_ntp :
                       tx_set ? ntp_cfg_r :
                       (tx_frame_done && ntp_on) ? ntp_cnt_r - 3'h1 :
                       ntp_cnt_r;
  // tx timer: reload per frame, stop once flag set
  wire [3:0] tt_nxt  = (wr_ctrl || tx_set) ? 4'h0 :
                       (tx_frame_done && tt_on) ? tt_cfg_r :
                       tt_step ? tt_cnt_r - 4'h1 : tt_cnt_r;
  wire [3:0] tsub_nxt = (wr_ctrl || tx_frame_done || tx_set) ? 4'h0 :
                        (tt_run && tk.unit_tick) ? tt_sub_r + 4'h1 :
                        tt_sub_r;

  // ----------------------------------------------------------------
  // receive mitigation
  // ----------------------------------------------------------------
  wire rt_on   = (rt_cfg_r != 4'h0);
  wire nrp_on  = (nrp_cfg_r != 3'h0);
  wire rt_run  = (rt_cnt_r != 4'h0);
  wire rt_step = rt_run && tk.unit_tick;
  wire rx_tmr_hit = rt_step && at_one(rt_cnt_r);
  wire rx_cnt_hit = rx_frame_done && nrp_on &&
                    at_one({1'b0, nrp_cnt_r});
  wire rx_nomit   = rx_frame_done && !nrp_on && !rt_on;
  wire rx_set     = rx_cnt_hit || rx_tmr_hit || rx_nomit;

  // rx counter: decrement per frame, reload on flag
  wire [2:0] nrp_nxt = wr_ctrl ? w_nrp :
                       rx_set ? nrp_cfg_r :
                       (rx_frame_done && nrp_on) ? nrp_cnt_r - 3'h1 :
                       nrp_cnt_r;
  // rx timer: start or reload per frame
  wire [3:0] rt_nxt  = (wr_ctrl || rx_set) ? 4'h0 :
                       (rx_frame_done && rt_on) ? rt_cfg_r :
                       rt_step ? rt_cnt_r - 4'h1 : rt_cnt_r;

  // ----------------------------------------------------------------
  // general-purpose timer
  // ----------------------------------------------------------------
  wire gp_run = (gp_cnt_r != 16'h0000);
  wire gp_hit = tk.long_tick && (gp_cnt_r == 16'h0001);
  // continuous reloads, one-shot stops
  wire [15:0] gp_nxt = wr_ctrl ? w_tim :
                       gp_hit ? (con_r ? tim_cfg_r : 16'h0000) :
                       (tk.long_tick && gp_run) ? gp_cnt_r - 16'h0001 :
                       gp_cnt_r;

  // ----------------------------------------------------------------
  // status, mask, interrupt
  // ----------------------------------------------------------------
  wire [2:0] st_set  = {gp_hit, rx_set, tx_set};
  wire [2:0] st_clr  = wr_stat ? reg_wdata[2:0] : 3'h0;
  // set wins over a write-one clear
  wire [2:0] st_nxt  = (st_r & ~st_clr) | st_set;
  wire [2:0] msk_nxt = wr_mask ? reg_wdata[2:0] : mask_r;

  // read mux, live counts in the control word
  wire [31:0] ctrl_rd = {cs_r, tt_cnt_r, ntp_cnt_r, rt_cnt_r,
                         nrp_cnt_r, con_r, gp_cnt_r};
  wire [31:0] rd_val  = (reg_addr == imt_pkg::CTRL_OFS) ? ctrl_rd :
                        (reg_addr == imt_pkg::STAT_OFS) ? {29'h0, st_r} :
                        (reg_addr == imt_pkg::MASK_OFS) ? {29'h0, mask_r} :
                        32'h0000_0000;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // programmed configuration; mode must precede value
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_r      <= imt_pkg::CTRL_RST[imt_pkg::CS_POS];
      tt_cfg_r  <= imt_pkg::CTRL_RST[imt_pkg::TT_LSB +: 4];
      ntp_cfg_r <= imt_pkg::CTRL_RST[imt_pkg::NTP_LSB +: 3];
      rt_cfg_r  <= imt_pkg::CTRL_RST[imt_pkg::RT_LSB +: 4];
      nrp_cfg_r <= imt_pkg::CTRL_RST[imt_pkg::NRP_LSB +: 3];
      con_r     <= imt_pkg::CTRL_RST[imt_pkg::CON_POS];
      tim_cfg_r <= imt_pkg::CTRL_RST[imt_pkg::TIM_LSB +: 16];
    end else if (wr_ctrl) begin
      cs_r      <= reg_wdata[imt_pkg::CS_POS];
      tt_cfg_r  <= w_tt;
      ntp_cfg_r <= w_ntp;
      rt_cfg_r  <= w_rt;
      nrp_cfg_r <= w_nrp;
      con_r     <= reg_wdata[imt_pkg::CON_POS];
      tim_cfg_r <= w_tim;
    end
  end

  // live counters
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ntp_cnt_r <= imt_pkg::CTRL_RST[imt_pkg::NTP_LSB +: 3];
      nrp_cnt_r <= imt_pkg::CTRL_RST[imt_pkg::NRP_LSB +: 3];
      tt_cnt_r  <= 4'h0;
      tt_sub_r  <= 4'h0;
      rt_cnt_r  <= 4'h0;
      gp_cnt_r  <= 16'h0000;
    end else begin
      ntp_cnt_r <= ntp_nxt;
      nrp_cnt_r <= nrp_nxt;
      tt_cnt_r  <= tt_nxt;
      tt_sub_r  <= tsub_nxt;
      rt_cnt_r  <= rt_nxt;
      gp_cnt_r  <= gp_nxt;
    end
  end

  // status, mask, read data, interrupt
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r    <= imt_pkg::STAT_RST;
      mask_r  <= imt_pkg::MASK_RST;
      rdata_r <= 32'h0000_0000;
      irq_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      mask_r  <= msk_nxt;
      rdata_r <= reg_rd ? rd_val : 32'h0000_0000;
      irq_r   <= |(st_nxt & msk_nxt);
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence rx_armed_s;
    rx_frame_done && rt_on && !nrp_on && !wr_ctrl && !rx_tmr_hit;
  endsequence
  sequence rx_quiet_s;
    !rx_frame_done && !wr_ctrl;
  endsequence

  tx_count_flag_a: assert property (
    tx_frame_done && ntp_on && ntp_cnt_r == 3'h1 |=> st_r[imt_pkg::ST_TX])
    else $error("tx count did not set tx flag");
  tx_count_dec_a: assert property (
    tx_frame_done && ntp_on && ntp_cnt_r > 3'h1 && !wr_ctrl && !tx_tmr_hit
    |=> ntp_cnt_r == $past(ntp_cnt_r) - 3'h1)
    else $error("tx count did not decrement");
  tx_count_off_a: assert property (
    tx_frame_done && !ntp_on && tt_on && !tx_tmr_hit && !wr_stat
    |=> st_r[imt_pkg::ST_TX] == $past(st_r[imt_pkg::ST_TX]))
    else $error("disabled tx count set tx flag");
  live_read_a: assert property (
    reg_rd && reg_addr == imt_pkg::CTRL_OFS && !wr_ctrl
    |=> reg_rdata[imt_pkg::RT_LSB +: 4] == $past(rt_cnt_r) &&
        reg_rdata[imt_pkg::NTP_LSB +: 3] == $past(ntp_cnt_r))
    else $error("control read not live count");
  rx_timer_a: assert property (
    rx_tmr_hit |=> st_r[imt_pkg::ST_RX] && rt_cnt_r == 4'h0)
    else $error("rx timer expiry missed");
  rx_reload_a: assert property (
    rx_armed_s ##1 rx_quiet_s |-> rt_cnt_r == rt_cfg_r)
    else $error("rx timer not reloaded by frame");
  rx_count_a: assert property (
    rx_cnt_hit && !wr_ctrl |=> nrp_cnt_r == nrp_cfg_r &&
                              st_r[imt_pkg::ST_RX])
    else $error("rx count not reloaded with flag");
  gp_mode_a: assert property (
    gp_hit && !wr_ctrl |=> gp_cnt_r == ($past(con_r) ? tim_cfg_r : 16'h0))
    else $error("timer mode wrong at expiry");
  tx_first_a: assert property (
    tx_tmr_hit && ntp_on && !wr_ctrl |=> ntp_cnt_r == ntp_cfg_r)
    else $error("timer flag did not reload counter");
  irq_level_a: assert property (
    irq == |(st_r & mask_r))
    else $error("irq disagrees with status and mask");

  // receive counter steps, flag and disable
  rx_count_dec_a: assert property (
    rx_frame_done && nrp_on && nrp_cnt_r > 3'h1 && !wr_ctrl &&
    !rx_tmr_hit |=> nrp_cnt_r == $past(nrp_cnt_r) - 3'h1)
    else $error("rx count did not decrement");
  rx_count_flag_a: assert property (
    rx_frame_done && nrp_on && nrp_cnt_r == 3'h1 |=> st_r[imt_pkg::ST_RX])
    else $error("rx count did not set rx flag");
  rx_count_off_a: assert property (
    rx_frame_done && !nrp_on && rt_on && !rx_tmr_hit && !wr_stat
    |=> st_r[imt_pkg::ST_RX] == $past(st_r[imt_pkg::ST_RX]))
    else $error("disabled rx count set rx flag");

  // transmit timer reload and expiry
  tx_reload_a: assert property (
    tx_frame_done && tt_on && !tx_set && !wr_ctrl
    |=> tt_cnt_r == tt_cfg_r && tt_sub_r == 4'h0)
    else $error("tx timer not reloaded by frame");
  tx_timer_a: assert property (
    tx_tmr_hit |=> st_r[imt_pkg::ST_TX] && tt_cnt_r == 4'h0)
    else $error("tx timer expiry missed");

  // gp timer steps once per iteration
  gp_step_a: assert property (
    tk.long_tick && gp_cnt_r > 16'h0001 && !wr_ctrl
    |=> gp_cnt_r == $past(gp_cnt_r) - 16'h0001)
    else $error("timer did not step on iteration");

  // read data stand one cycle only
  rd_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the mitigation and gp timer block
// assumes imt_top with shortened unit parameters, one clock
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int U = 4;      // short unit at 100 Mbps, cycles
  localparam int U10 = 8;    // short unit at 10 Mbps, cycles
  localparam int L = 16 * U; // long unit, cycles
  localparam logic [7:0] CT = imt_pkg::CTRL_OFS;
  localparam logic [7:0] ST = imt_pkg::STAT_OFS;
  localparam logic [7:0] MK = imt_pkg::MASK_OFS;

  logic        core_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        speed_100;
  logic        tx_frame_done;
  logic        rx_frame_done;
  logic        irq;
  logic [31:0] v;
  int          n_errors;
  int          compares;
  int          n;

  imt_top #(.SHORT_100_CYC(U), .SHORT_10_CYC(U10)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .speed_100(speed_100),
    .tx_frame_done(tx_frame_done), .rx_frame_done(rx_frame_done),
    .irq(irq));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic chk_rng(input string nm, input int g, lo, hi);
    compares++;
    if (g < lo || g > hi) begin
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask

  task automatic frame(input bit tx);
    if (tx) tx_frame_done <= 1'b1;
    else rx_frame_done <= 1'b1;
    @(posedge core_clk);
    tx_frame_done <= 1'b0;
    rx_frame_done <= 1'b0;
  endtask

  // cycles until irq rises, bounded
  task automatic wait_irq(input int max, output int k);
    k = 0;
    #1;
    while (irq !== 1'b1 && k < max) begin
      @(posedge core_clk);
      #1 k++;
    end
    // back onto the clock edge before the next request
    @(posedge core_clk);
    if (irq !== 1'b1) begin
      $display("[ERR] irq wait exp 1 got %b", irq);
      n_errors++;
      test_done();
    end
  endtask

  function automatic logic [31:0] cw(logic cs, logic [3:0] tt,
      logic [2:0] tx_frame_count_limit, logic [3:0] rt, logic [2:0] rx_frame_count_limit, logic continuous_mode_bit,
      logic [15:0] tim);
    cw = 32'h0000_0000;
    cw[imt_pkg::CS_POS] = cs;
    cw[imt_pkg::TT_LSB +: 4] = tt;
    cw[imt_pkg::NTP_LSB +: 3] = tx_frame_count_limit;
    cw[imt_pkg::RT_LSB +: 4] = rt;
    cw[imt_pkg::NRP_LSB +: 3] = rx_frame_count_limit;
    cw[imt_pkg::CON_POS] = continuous_mode_bit;
    cw[imt_pkg::TIM_LSB +: 16] = tim;
  endfunction

  // enable one bit, clear status, optional early frame, then time irq
  task automatic timed(input bit tx, input int pre, lo, hi);
    wr(MK, tx ? 32'h0000_0001 : 32'h0000_0002);
    wr(ST, 32'h0000_0007);
    if (pre > 0) begin
      frame(tx);
      repeat (pre) @(posedge core_clk);
    end
    frame(tx);
    wait_irq(400, n);
    chk_rng("irq delay", n, lo, hi);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(CT, v); chk("ctrl reset", 32'h0000_0000, v);
    rd(ST, v); chk("stat reset", 32'h0000_0000, v);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(MK, v); chk("mask reset", 32'h0000_0000, v);
    rd(8'h0C, v); chk("unmapped", 32'h0000_0000, v);
    chk("irq reset", 32'h0, {31'h0, irq});
  endtask

  task automatic t_tx_count;
    wr(CT, cw(0, 0, 2, 0, 0, 0, 0));
    frame(1);
    rd(CT, v); chk("ntp live", 32'h1, {29'h0, v[26:24]});
    rd(ST, v); chk("stat early", 32'h0, v);
    frame(1);
    rd(ST, v); chk("tx flag", 32'h1, v);
    rd(CT, v); chk("ntp reload", 32'h2, {29'h0, v[26:24]});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(MK, 32'h0000_0001);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(ST, 32'h0000_0001);
    chk("irq off", 32'h0, {31'h0, irq});
    rd(ST, v); chk("tx clear", 32'h0, v);
  endtask

  task automatic t_zero;
    wr(CT, cw(0, 0, 0, 0, 0, 0, 0));
    frame(1);
    frame(0);
    rd(ST, v); chk("zero fields", 32'h3, v);
    wr(ST, 32'h0000_0007);
  endtask

  task automatic t_rx_count;
    wr(CT, cw(0, 0, 0, 0, 3, 0, 0));
    frame(0);
    frame(0);
    rd(CT, v); chk("nrp live", 32'h1, {29'h0, v[19:17]});
    rd(ST, v); chk("rx early", 32'h0, v);
    frame(0);
    rd(ST, v); chk("rx flag", 32'h2, v);
    rd(CT, v); chk("nrp reload", 32'h3, {29'h0, v[19:17]});
    // counter reached before a long timer
    wr(CT, cw(0, 0, 0, 15, 1, 0, 0));
    wr(ST, 32'h0000_0007);
    frame(0);
    rd(ST, v); chk("count first", 32'h2, v);
  endtask

  task automatic t_timers;
    speed_100 <= 1'b1;
    wr(CT, cw(1, 0, 0, 3, 7, 0, 0));
    timed(0, 0, 2 * U - 1, 3 * U + 3);
    wr(CT, cw(1, 0, 0, 3, 7, 0, 0));
    timed(0, 6, 2 * U - 1, 3 * U + 3);
    wr(CT, cw(1, 2, 7, 0, 0, 0, 0));
    timed(1, 0, 16 * U - 1, 32 * U + 3);
    wr(CT, cw(1, 1, 0, 0, 0, 0, 0));
    timed(1, 0, 16 * U - 3, 16 * U + 3);
    wr(CT, cw(0, 0, 0, 2, 0, 0, 0));
    timed(0, 0, L - 1, 2 * L + 3);
    speed_100 <= 1'b0;
    wr(CT, cw(1, 0, 0, 2, 0, 0, 0));
    timed(0, 0, U10 - 1, 2 * U10 + 3);
    speed_100 <= 1'b1;
    wr(CT, cw(0, 0, 0, 0, 0, 0, 0));
  endtask

  task automatic t_gp;
    wr(MK, 32'h0000_0004);
    wr(ST, 32'h0000_0007);
    wr(CT, cw(0, 0, 0, 0, 0, 0, 2));
    wait_irq(400, n);
    chk_rng("gp one-shot", n, L - 3, 2 * L + 3);
    rd(CT, v); chk("tim idle", 32'h0, {16'h0, v[15:0]});
    wr(ST, 32'h0000_0004);
    repeat (3 * L) @(posedge core_clk);
    rd(ST, v); chk("no repeat", 32'h0, v);
    wr(CT, cw(0, 0, 0, 0, 0, 1, 0));
    wr(CT, cw(0, 0, 0, 0, 0, 1, 1));
    wait_irq(400, n);
    wr(ST, 32'h0000_0004);
    wait_irq(400, n);
    chk_rng("gp period", n, L - 6, L + 3);
    wr(CT, cw(0, 0, 0, 0, 0, 0, 0));
    wr(ST, 32'h0000_0007);
  endtask

  // ----------------------------------------------------------------
  // clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    n_errors = 0;
    compares = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    speed_100 = 1'b1;
    tx_frame_done = 1'b0;
    rx_frame_done = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_tx_count();
    t_zero();
    t_rx_count();
    t_timers();
    t_gp();
    test_done();
  end
endmodule
`default_nettype wire
